/* rtl/srp_pkg.sv */
// constants for the status register one protection block
// shared by the main module and its assertions
package srp_pkg;
    localparam int unsigned SRP_DW = 8;
    localparam int unsigned SRP_AW = 24;
    localparam int unsigned SRP_SYNC_STAGES = 3;
    // command opcodes
    localparam logic [7:0] SRP_OP_WRITE_REGS = 8'h01;
    localparam logic [7:0] SRP_OP_READ_ANY = 8'h65;
    localparam logic [7:0] SRP_OP_WRITE_ANY = 8'h71;
    localparam logic [7:0] SRP_OP_PROGRAM = 8'h02;
    localparam logic [7:0] SRP_OP_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] SRP_OP_BULK_ERASE = 8'h60;
    // register addresses for the any-register commands
    localparam logic [23:0] SRP_ADDR_STATUS_ONE_NONVOLATILE = 24'h000000;
    localparam logic [23:0] SRP_ADDR_CONFIG_ONE_NONVOLATILE = 24'h000002;
    localparam logic [23:0] SRP_ADDR_STATUS_ONE_VOLATILE = 24'h800000;
    localparam logic [23:0] SRP_ADDR_CONFIG_ONE_VOLATILE = 24'h800002;
    // field positions of status register one
    localparam int unsigned SRP_LOCK_BIT = 7;
    localparam int unsigned SRP_PERR_BIT = 6;
    localparam int unsigned SRP_EERR_BIT = 5;
    localparam int unsigned SRP_BP_HI = 4;
    localparam int unsigned SRP_BP_LO = 2;
    localparam int unsigned SRP_WEL_BIT = 1;
    localparam int unsigned SRP_BUSY_BIT = 0;
    // field position of the protection type in config register one
    localparam int unsigned SRP_PTYPE_BIT = 3;
    // shipped and fixed values
    localparam logic [7:0] SRP_STATUS_ONE_NONVOLATILE_SHIPPED = 8'h00;
    localparam logic [7:0] SRP_CONFIG_ONE_NONVOLATILE_SHIPPED = 8'h00;
    localparam logic [2:0] SRP_BP_ALL_ONES = 3'h7;
    localparam logic [2:0] SRP_BP_NONE = 3'h0;
    localparam logic [7:0] SRP_RO_MASK = 8'h63;
endpackage

/* rtl/srp_pin_sync.sv */
// three-stage synchroniser for the write-protect pin
// assumes an asynchronous pin; level taken when stages two and three agree
`timescale 1ns/1ps
module srp_pin_sync
    import srp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_out
);
    logic [SRP_SYNC_STAGES-1:0] stage_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage_q <= '0;
        end
        else
        begin
            stage_q <= {stage_q[SRP_SYNC_STAGES-2:0], pin_in};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            level_out <= 1'b0;
        end
        else if (stage_q[SRP_SYNC_STAGES-2] == stage_q[SRP_SYNC_STAGES-1])
        begin
            level_out <= stage_q[SRP_SYNC_STAGES-1];
        end
    end
endmodule

/* rtl/srp_status_one.sv */
// status register one, non-volatile and volatile copies, with write protection
// assumes a command decoder on MCLK delivering one-cycle command strobes
//
// Summary of operation
// [R1] lock set and pin low: refuse register writes
// [R2] pin high: register writes accepted
// [R3] lock clear: pin ignored, writes accepted
// [R4] pin affects only status and config one
// [R5] volatile bit 7 mirrors the lock bit
// [R6] error default bits are read-only
// [R7] latch and busy default bits read-only
// [R8] type zero: write nv protection, copy volatile
// [R9] type one: write only volatile protection
// [R10] switch to volatile sets nv protection ones
// [R11] protected region rejects program and erase
// [R12] bulk erase only with protection all zero
// [R13] shipped: protection zero, lock zero
// [R14] reset reloads volatile from non-volatile
// [R15] volatile protection writable only when type one
// [R16] writes keep every read-only default bit
`timescale 1ns/1ps
module srp_status_one
    import srp_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic RELOAD,
    input wire logic WP_N,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_OP,
    input wire logic [SRP_AW-1:0] CMD_ADDR,
    input wire logic [SRP_DW-1:0] CMD_DATA,
    input wire logic CMD_HAS2,
    input wire logic [SRP_DW-1:0] CMD_DATA2,
    input wire logic CMD_WEL,
    input wire logic REGION_PROTECTED,
    output logic [SRP_DW-1:0] STATUS_V,
    output logic [SRP_DW-1:0] CONFIG_V,
    output logic [2:0] ACTIVE_BP,
    output logic [SRP_DW-1:0] RD_DATA,
    output logic RD_VALID,
    output logic CMD_DONE,
    output logic CMD_REJECT,
    output logic ARRAY_GO,
    output logic ERASE_GO
);
    logic wp_level;
    logic [7:0] status_one_nonvolatile_q;
    logic [7:0] status_one_nonvolatile_d;
    logic [7:0] status_one_volatile_q;
    logic [7:0] status_one_volatile_d;
    logic [7:0] config_one_nonvolatile_q;
    logic [7:0] config_one_nonvolatile_d;
    logic [7:0] config_one_volatile_q;
    logic [7:0] config_one_volatile_d;
    logic is_wrr;
    logic is_write_any_reg_cmd;
    logic tgt_sr_nv;
    logic tgt_sr_v;
    logic tgt_cr_nv;
    logic tgt_cr_v;
    logic guarded;
    logic locked;
    logic write_ok;
    logic ptype;
    logic [2:0] active_bp;
    logic is_array_op;
    logic is_bulk;
    logic array_ok;
    logic bulk_ok;
    logic [7:0] rd_sel;
    logic rd_hit;

    srp_pin_sync u_wp_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .pin_in(WP_N),
        .level_out(wp_level)
    );

    assign is_wrr = CMD_OP == SRP_OP_WRITE_REGS;
    assign is_write_any_reg_cmd = CMD_OP == SRP_OP_WRITE_ANY;
    assign tgt_sr_nv = is_wrr || (is_write_any_reg_cmd && CMD_ADDR == SRP_ADDR_STATUS_ONE_NONVOLATILE);
    assign tgt_sr_v = is_write_any_reg_cmd && CMD_ADDR == SRP_ADDR_STATUS_ONE_VOLATILE;
    assign tgt_cr_nv = (is_wrr && CMD_HAS2) || (is_write_any_reg_cmd && CMD_ADDR == SRP_ADDR_CONFIG_ONE_NONVOLATILE);
    assign tgt_cr_v = is_write_any_reg_cmd && CMD_ADDR == SRP_ADDR_CONFIG_ONE_VOLATILE;
    // only status one and config one writes see the pin
    assign guarded = CMD_VALID && (tgt_sr_nv || tgt_sr_v || tgt_cr_nv || tgt_cr_v); // see [R4]
    assign locked = status_one_nonvolatile_q[SRP_LOCK_BIT] && !wp_level; // see [R1] see [R2] see [R3]
    assign write_ok = guarded && CMD_WEL && !locked;
    assign ptype = config_one_nonvolatile_q[SRP_PTYPE_BIT];
    assign active_bp = ptype ? status_one_volatile_q[SRP_BP_HI:SRP_BP_LO] : status_one_nonvolatile_q[SRP_BP_HI:SRP_BP_LO];
    assign is_array_op = CMD_VALID && (CMD_OP == SRP_OP_PROGRAM || CMD_OP == SRP_OP_SECTOR_ERASE);
    assign is_bulk = CMD_VALID && CMD_OP == SRP_OP_BULK_ERASE;
    assign array_ok = CMD_WEL && !(REGION_PROTECTED && active_bp != SRP_BP_NONE); // see [R11]
    assign bulk_ok = CMD_WEL && active_bp == SRP_BP_NONE; // see [R12]

    // next values of the configuration copies
    always_comb
    begin
        config_one_nonvolatile_d = config_one_nonvolatile_q;
        config_one_volatile_d = config_one_volatile_q;
        if (write_ok && tgt_cr_nv)
        begin
            config_one_nonvolatile_d = is_wrr ? CMD_DATA2 : CMD_DATA;
            // type select is one-way
            config_one_nonvolatile_d[SRP_PTYPE_BIT] = ptype || config_one_nonvolatile_d[SRP_PTYPE_BIT];
            config_one_volatile_d = config_one_nonvolatile_d;
        end
        else if (write_ok && tgt_cr_v)
        begin
            config_one_volatile_d = CMD_DATA;
            config_one_volatile_d[SRP_PTYPE_BIT] = ptype;
        end
    end

    // next values of the status copies
    always_comb
    begin
        status_one_nonvolatile_d = status_one_nonvolatile_q;
        status_one_volatile_d = status_one_volatile_q;
        if (write_ok && tgt_sr_nv)
        begin
            status_one_nonvolatile_d[SRP_LOCK_BIT] = CMD_DATA[SRP_LOCK_BIT];
            if (!ptype)
            begin
                status_one_nonvolatile_d[SRP_BP_HI:SRP_BP_LO] = CMD_DATA[SRP_BP_HI:SRP_BP_LO]; // see [R8]
            end
            else if (is_wrr)
            begin
                status_one_volatile_d[SRP_BP_HI:SRP_BP_LO] = CMD_DATA[SRP_BP_HI:SRP_BP_LO]; // see [R9]
            end
        end
        else if (write_ok && tgt_sr_v && ptype)
        begin
            status_one_volatile_d[SRP_BP_HI:SRP_BP_LO] = CMD_DATA[SRP_BP_HI:SRP_BP_LO]; // see [R15]
        end
        if (config_one_nonvolatile_d[SRP_PTYPE_BIT] && !ptype)
        begin
            status_one_nonvolatile_d[SRP_BP_HI:SRP_BP_LO] = SRP_BP_ALL_ONES; // see [R10]
        end
        if (!config_one_nonvolatile_d[SRP_PTYPE_BIT])
        begin
            status_one_volatile_d[SRP_BP_HI:SRP_BP_LO] = status_one_nonvolatile_d[SRP_BP_HI:SRP_BP_LO]; // see [R8] see [R15]
        end
        status_one_volatile_d[SRP_LOCK_BIT] = status_one_nonvolatile_d[SRP_LOCK_BIT]; // see [R5]
    end

    // non-volatile cells: factory state on power-up only
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            status_one_nonvolatile_q <= SRP_STATUS_ONE_NONVOLATILE_SHIPPED; // see [R13]
            config_one_nonvolatile_q <= SRP_CONFIG_ONE_NONVOLATILE_SHIPPED;
        end
        else
        begin
            // read-only defaults never take user data
            status_one_nonvolatile_q <= (status_one_nonvolatile_d & ~SRP_RO_MASK) | (status_one_nonvolatile_q & SRP_RO_MASK); // see [R6] [R7] [R16]
            config_one_nonvolatile_q <= config_one_nonvolatile_d;
        end
    end

    // volatile copies: reloaded from the non-volatile cells
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            status_one_volatile_q <= SRP_STATUS_ONE_NONVOLATILE_SHIPPED;
            config_one_volatile_q <= SRP_CONFIG_ONE_NONVOLATILE_SHIPPED;
        end
        else if (RELOAD)
        begin
            status_one_volatile_q <= status_one_nonvolatile_q; // see [R14]
            config_one_volatile_q <= config_one_nonvolatile_q;
        end
        else
        begin
            status_one_volatile_q <= (status_one_volatile_d & ~SRP_RO_MASK) | (status_one_volatile_q & SRP_RO_MASK); // see [R16]
            config_one_volatile_q <= config_one_volatile_d;
        end
    end

    // read-any-register decode
    always_comb
    begin
        rd_hit = 1'b1;
        rd_sel = '0;
        unique case (CMD_ADDR)
            SRP_ADDR_STATUS_ONE_NONVOLATILE: rd_sel = status_one_nonvolatile_q;
            SRP_ADDR_STATUS_ONE_VOLATILE: rd_sel = status_one_volatile_q;
            SRP_ADDR_CONFIG_ONE_NONVOLATILE: rd_sel = config_one_nonvolatile_q;
            SRP_ADDR_CONFIG_ONE_VOLATILE: rd_sel = config_one_volatile_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // command answers
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            RD_DATA <= '0;
            RD_VALID <= 1'b0;
            CMD_DONE <= 1'b0;
            CMD_REJECT <= 1'b0;
            ARRAY_GO <= 1'b0;
            ERASE_GO <= 1'b0;
        end
        else
        begin
            RD_VALID <= CMD_VALID && CMD_OP == SRP_OP_READ_ANY && rd_hit;
            RD_DATA <= rd_sel;
            CMD_DONE <= write_ok;
            ARRAY_GO <= is_array_op && array_ok; // see [R11]
            ERASE_GO <= is_bulk && bulk_ok; // see [R12]
            CMD_REJECT <= (guarded && !write_ok) // see [R1]
                || (is_array_op && !array_ok)
                || (is_bulk && !bulk_ok);
        end
    end

    // visible register state
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            STATUS_V <= SRP_STATUS_ONE_NONVOLATILE_SHIPPED;
            CONFIG_V <= SRP_CONFIG_ONE_NONVOLATILE_SHIPPED;
            ACTIVE_BP <= SRP_BP_NONE;
        end
        else
        begin
            STATUS_V <= status_one_volatile_q;
            CONFIG_V <= config_one_volatile_q;
            ACTIVE_BP <= active_bp;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_locked_write;
        guarded && locked;
    endsequence

    sequence s_open_write;
        guarded && CMD_WEL && (wp_level || !status_one_nonvolatile_q[SRP_LOCK_BIT]) && !RELOAD;
    endsequence

    property p_lock_refuses;
        s_locked_write |=> $stable(status_one_nonvolatile_q) && $stable(config_one_nonvolatile_q) && CMD_REJECT && !CMD_DONE;
    endproperty
    a_lock_refuses: assert property (p_lock_refuses) // see [R1]
        else $error("locked write took effect");

    property p_lock_keeps_volatile;
        s_locked_write ##0 !RELOAD |=> $stable(status_one_volatile_q) && $stable(config_one_volatile_q);
    endproperty
    a_lock_keeps_volatile: assert property (p_lock_keeps_volatile) // see [R1]
        else $error("locked write changed volatile copy");

    property p_open_accepts;
        s_open_write |=> CMD_DONE && !CMD_REJECT;
    endproperty
    a_open_accepts: assert property (p_open_accepts) // see [R2]
        else $error("open write not done");

    property p_lock_bit_written;
        s_open_write ##0 tgt_sr_nv |=> status_one_nonvolatile_q[SRP_LOCK_BIT] == $past(CMD_DATA[SRP_LOCK_BIT]);
    endproperty
    a_lock_bit_written: assert property (p_lock_bit_written) // see [R3]
        else $error("lock bit not written");

    property p_other_reg_free;
        CMD_VALID && is_write_any_reg_cmd && !guarded |=> !CMD_REJECT && !CMD_DONE;
    endproperty
    a_other_reg_free: assert property (p_other_reg_free) // see [R4]
        else $error("pin gated other reg");

    property p_mirror;
        !RELOAD |=> status_one_volatile_q[SRP_LOCK_BIT] == status_one_nonvolatile_q[SRP_LOCK_BIT];
    endproperty
    a_mirror: assert property (p_mirror) else $error("lock mirror mismatch"); // see [R5]

    property p_ro_stable;
        ##1 (status_one_nonvolatile_q & SRP_RO_MASK) == ($past(status_one_nonvolatile_q) & SRP_RO_MASK);
    endproperty
    a_ro_stable: assert property (p_ro_stable) // see [R6]
        else $error("read-only default changed");

    property p_nv_bp_write;
        s_open_write ##0 tgt_sr_nv && !ptype && !config_one_nonvolatile_d[SRP_PTYPE_BIT]
            |=> status_one_nonvolatile_q[SRP_BP_HI:SRP_BP_LO] == $past(CMD_DATA[SRP_BP_HI:SRP_BP_LO])
            && status_one_volatile_q[SRP_BP_HI:SRP_BP_LO] == status_one_nonvolatile_q[SRP_BP_HI:SRP_BP_LO];
    endproperty
    a_nv_bp_write: assert property (p_nv_bp_write) // see [R8]
        else $error("nv protection write wrong");

    property p_v_bp_write;
        s_open_write ##0 (is_wrr || tgt_sr_v) && ptype
            |=> $stable(status_one_nonvolatile_q[SRP_BP_HI:SRP_BP_LO])
            && status_one_volatile_q[SRP_BP_HI:SRP_BP_LO] == $past(CMD_DATA[SRP_BP_HI:SRP_BP_LO]);
    endproperty
    a_v_bp_write: assert property (p_v_bp_write) // see [R9]
        else $error("volatile protection write wrong");

    property p_switch_ones;
        $rose(config_one_nonvolatile_q[SRP_PTYPE_BIT]) |-> status_one_nonvolatile_q[SRP_BP_HI:SRP_BP_LO] == SRP_BP_ALL_ONES
            ##1 status_one_nonvolatile_q[SRP_BP_HI:SRP_BP_LO] == SRP_BP_ALL_ONES;
    endproperty
    a_switch_ones: assert property (p_switch_ones) // see [R10]
        else $error("switch did not set ones");

    property p_array_block;
        is_array_op && REGION_PROTECTED && active_bp != SRP_BP_NONE |=> !ARRAY_GO && CMD_REJECT;
    endproperty
    a_array_block: assert property (p_array_block) // see [R11]
        else $error("protected region not refused");

    property p_bulk_gate;
        is_bulk && CMD_WEL |=> ERASE_GO == ($past(active_bp) == SRP_BP_NONE);
    endproperty
    a_bulk_gate: assert property (p_bulk_gate) else $error("bulk erase gate wrong"); // see [R12]

    property p_reload;
        RELOAD |=> status_one_volatile_q == $past(status_one_nonvolatile_q) && config_one_volatile_q == $past(config_one_nonvolatile_q);
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not copy"); // see [R14]
endmodule

/* dv/srp_host_model.sv */
// host-side command source for the status register one block
// assumes the bench calls issue() and that the answers are pulses
`timescale 1ns/1ps
module srp_host_model
    import srp_pkg::*;
(
    input wire logic MCLK,
    output logic CMD_VALID,
    output logic [7:0] CMD_OP,
    output logic [SRP_AW-1:0] CMD_ADDR,
    output logic [SRP_DW-1:0] CMD_DATA,
    output logic CMD_HAS2,
    output logic [SRP_DW-1:0] CMD_DATA2,
    input wire logic [SRP_DW-1:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic CMD_DONE,
    input wire logic CMD_REJECT,
    input wire logic ARRAY_GO,
    input wire logic ERASE_GO
);
    initial
    begin
        CMD_VALID = 1'b0;
        CMD_OP = 8'h00;
        CMD_ADDR = 24'h000000;
        CMD_DATA = 8'h00;
        CMD_HAS2 = 1'b0;
        CMD_DATA2 = 8'h00;
    end

    // one strobe, then gather every answer pulse over three cycles
    task automatic issue(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] d1,
        input logic has2, input logic [7:0] d2, output logic [4:0] flags, output logic [7:0] rd);
        flags = 5'h00;
        rd = 8'h00;
        @(posedge MCLK);
        #2;
        CMD_VALID = 1'b1;
        CMD_OP = op;
        CMD_ADDR = addr;
        CMD_DATA = d1;
        CMD_HAS2 = has2;
        CMD_DATA2 = d2;
        @(posedge MCLK);
        #2;
        CMD_VALID = 1'b0;
        // released lines show the inverse, never a stale copy
        CMD_OP = ~op;
        CMD_ADDR = ~addr;
        CMD_DATA = ~d1;
        CMD_HAS2 = ~has2;
        CMD_DATA2 = ~d2;
        repeat (3)
        begin
            flags |= {ERASE_GO, ARRAY_GO, CMD_REJECT, CMD_DONE, RD_VALID};
            if (RD_VALID === 1'b1)
                rd = RD_DATA;
            @(posedge MCLK);
            #2;
        end
    endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the status register one protection block
// assumes srp_host_model drives the command port
`timescale 1ns/1ps
module testbench
    import srp_pkg::*;
;
    localparam logic [4:0] F_NONE = 5'h00;
    localparam logic [4:0] F_RD = 5'h01;
    localparam logic [4:0] F_DONE = 5'h02;
    localparam logic [4:0] F_REJ = 5'h04;
    localparam logic [4:0] F_AGO = 5'h08;
    localparam logic [4:0] F_EGO = 5'h10;
    logic mclk, sys_rst, reload, wp_n, cmd_wel, region_prot;
    logic cmd_valid, cmd_has2, rd_valid, cmd_done, cmd_reject, array_go, erase_go;
    logic [7:0] cmd_op, cmd_data, cmd_data2, status_v, config_v, rd_data, rd, d, e;
    logic [SRP_AW-1:0] cmd_addr;
    logic [2:0] active_bp;
    logic [4:0] flags;
    int n_fail, checks;

    srp_status_one i_dut (.MCLK(mclk), .SYS_RST(sys_rst), .RELOAD(reload), .WP_N(wp_n),
        .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
        .CMD_HAS2(cmd_has2), .CMD_DATA2(cmd_data2), .CMD_WEL(cmd_wel),
        .REGION_PROTECTED(region_prot), .STATUS_V(status_v), .CONFIG_V(config_v),
        .ACTIVE_BP(active_bp), .RD_DATA(rd_data), .RD_VALID(rd_valid), .CMD_DONE(cmd_done),
        .CMD_REJECT(cmd_reject), .ARRAY_GO(array_go), .ERASE_GO(erase_go));
    srp_host_model i_host (.MCLK(mclk), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_HAS2(cmd_has2), .CMD_DATA2(cmd_data2),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .CMD_DONE(cmd_done), .CMD_REJECT(cmd_reject),
        .ARRAY_GO(array_go), .ERASE_GO(erase_go));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] dat,
        input logic has2 = 1'b0, input logic [7:0] d2 = 8'h00);
        i_host.issue(op, addr, dat, has2, d2, flags, rd);
    endtask
    task automatic ans(input logic [4:0] exp);
        check("answer", {3'h0, flags}, {3'h0, exp});
    endtask
    task automatic rd_nv(input logic [7:0] exp);
        cmd(SRP_OP_READ_ANY, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h00);
        check("nv_read", rd, exp);
        check("rd_valid", {3'h0, flags}, {3'h0, F_RD});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic set_wp(input logic level);
        wp_n = level;
        wait_cyc(6);
    endtask
    // only lock and protection bits survive a user write
    function automatic logic [7:0] sr_exp(input logic [7:0] v);
        return v & 8'h9C;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end

    initial
    begin
        sys_rst = 1'b1;
        reload = 1'b0;
        wp_n = 1'b1;
        cmd_wel = 1'b1;
        region_prot = 1'b0;
        n_fail = 0;
        checks = 0;
        d = 8'($urandom(23381));
        repeat (12) @(posedge mclk);
        #2;
        sys_rst = 1'b0;
        wait_cyc(4);
        check("status_v", status_v, 8'h00);
        check("active_bp", {5'h00, active_bp}, 8'h00);
        rd_nv(8'h00);
        cmd_wel = 1'b0;
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h1C);
        ans(F_REJ);
        check("status_v", status_v, 8'h00);
        cmd_wel = 1'b1;
        $display("test shipped done");
        for (int i = 0; i < 8; i++)
        begin
            d = 8'($urandom);
            e = sr_exp(d);
            cmd(i[0] ? SRP_OP_WRITE_ANY : SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, d);
            ans(F_DONE);
            check("status_v", status_v, e);
            check("active_bp", {5'h00, active_bp}, {5'h00, e[4:2]});
            rd_nv(e);
        end
        $display("test random writes done");
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h80);
        ans(F_DONE);
        set_wp(1'b0);
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h1C, 1'b1, 8'h08);
        ans(F_REJ);
        check("status_v", status_v, 8'h80);
        cmd(SRP_OP_WRITE_ANY, SRP_ADDR_CONFIG_ONE_NONVOLATILE, 8'h08);
        ans(F_REJ);
        check("config_v", config_v, 8'h00);
        cmd(SRP_OP_WRITE_ANY, 24'h000004, 8'hFF);
        ans(F_NONE);
        set_wp(1'b1);
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h84);
        ans(F_DONE);
        check("status_v", status_v, 8'h84);
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h04);
        ans(F_DONE);
        set_wp(1'b0);
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h08);
        ans(F_DONE);
        check("status_v", status_v, 8'h08);
        $display("test lock done");
        cmd(SRP_OP_BULK_ERASE, 24'h000000, 8'h00);
        ans(F_REJ);
        region_prot = 1'b1;
        cmd(SRP_OP_PROGRAM, 24'h000100, 8'h00);
        ans(F_REJ);
        cmd(SRP_OP_SECTOR_ERASE, 24'h000100, 8'h00);
        ans(F_REJ);
        region_prot = 1'b0;
        cmd(SRP_OP_PROGRAM, 24'h000100, 8'h00);
        ans(F_AGO);
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h00);
        ans(F_DONE);
        cmd(SRP_OP_WRITE_ANY, SRP_ADDR_STATUS_ONE_VOLATILE, 8'hF7);
        ans(F_DONE);
        check("status_v", status_v, 8'h00);
        cmd_wel = 1'b0;
        cmd(SRP_OP_BULK_ERASE, 24'h000000, 8'h00);
        ans(F_REJ);
        cmd_wel = 1'b1;
        region_prot = 1'b1;
        cmd(SRP_OP_BULK_ERASE, 24'h000000, 8'h00);
        ans(F_EGO);
        cmd(SRP_OP_SECTOR_ERASE, 24'h000100, 8'h00);
        ans(F_AGO);
        $display("test erase done");
        cmd(SRP_OP_WRITE_ANY, SRP_ADDR_CONFIG_ONE_NONVOLATILE, 8'h08);
        ans(F_DONE);
        check("config_v3", {7'h00, config_v[SRP_PTYPE_BIT]}, 8'h01);
        rd_nv(8'h1C);
        cmd(SRP_OP_WRITE_REGS, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h08);
        check("status_v", status_v, 8'h08);
        check("active_bp", {5'h00, active_bp}, 8'h02);
        rd_nv(8'h1C);
        cmd(SRP_OP_WRITE_ANY, SRP_ADDR_STATUS_ONE_VOLATILE, 8'hF7);
        ans(F_DONE);
        check("status_v", status_v, 8'h14);
        check("active_bp", {5'h00, active_bp}, 8'h05);
        cmd(SRP_OP_WRITE_ANY, SRP_ADDR_CONFIG_ONE_VOLATILE, 8'h00);
        ans(F_DONE);
        check("config_v", config_v, 8'h08);
        cmd(SRP_OP_WRITE_ANY, SRP_ADDR_STATUS_ONE_NONVOLATILE, 8'h00);
        rd_nv(8'h1C);
        reload = 1'b1;
        wait_cyc(1);
        reload = 1'b0;
        wait_cyc(3);
        check("status_v", status_v, 8'h1C);
        check("config_v", config_v, 8'h08);
        cmd(SRP_OP_BULK_ERASE, 24'h000000, 8'h00);
        ans(F_REJ);
        $display("test volatile type done");
        end_of_test();
    end
endmodule
